// ---- verilog/cldc_pkg.sv ----
// package for the configuration lock and debug control block: map, field layout, reset values, carriers.
// assumes a 32-bit axi4-lite register bus and a system unlock qualifier on the same clock.
package cldc_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W  = 6;
    localparam int unsigned MAX_WORDS = 64;

    // register map: region codes for address bits 11:8, then byte addresses
    localparam logic [3:0] REGION_CFG = 4'h0;
    localparam logic [3:0] REGION_PPS = 4'h1;
    localparam logic [3:0] REGION_PMD = 4'h2;
    localparam logic [ADDR_W-1:0] CFG_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] PPS_BASE   = 12'h100;
    localparam logic [ADDR_W-1:0] PMD_BASE   = 12'h200;

    // configuration_control fields
    localparam int unsigned BIT_PIN_LOCK = 13;
    localparam int unsigned BIT_MOD_LOCK = 12;
    localparam int unsigned BIT_DBG_EN   = 3;
    localparam int unsigned BIT_TDO_SEL  = 0;
    localparam logic [DATA_W-1:0] CFG_READ_ONES = 32'h0000_0006;
    localparam logic RST_PIN_LOCK = 1'h0;
    localparam logic RST_MOD_LOCK = 1'h0;
    localparam logic RST_DBG_EN   = 1'h1;
    localparam logic RST_TDO_SEL  = 1'h1;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        CLDC_RG_CFG  = 2'b00,
        CLDC_RG_PPS  = 2'b01,
        CLDC_RG_PMD  = 2'b10,
        CLDC_RG_NONE = 2'b11
    } cldc_region_e;

    typedef struct packed {
        cldc_region_e     region;
        logic [IDX_W-1:0] idx;
    } cldc_decode_s;

    typedef struct packed {
        logic pin_select_lock;
        logic module_disable_lock;
        logic debug_port_enable;
        logic two_wire_data_out_select;
    } cldc_cfg_s;

    typedef struct packed {
        logic              en;
        logic [IDX_W-1:0]  idx;
        logic [DATA_W-1:0] data;
        logic [3:0]        strb;
    } cldc_wreq_s;

    function automatic logic [DATA_W-1:0] cldc_merge(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [3:0]        strb);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ---- verilog/cldc_lock_bank.sv ----
// lockable bank of software-written words, used for pin-select mapping and module-disable registers.
// assumes the write request comes from the bus slave on the same clock, at most one per cycle.
`timescale 1ns/1ps
module cldc_lock_bank
    import cldc_pkg::*;
#(
    parameter int unsigned COUNT = 8
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    lock,
    input  wire cldc_wreq_s              wreq,
    output logic [COUNT-1:0][DATA_W-1:0] words
);

    if (COUNT < 1 || COUNT > MAX_WORDS) begin : g_bad_count
        $error("cldc_lock_bank: COUNT out of range");
    end

    typedef struct packed {
        logic [COUNT-1:0][DATA_W-1:0] w;
    } cldc_bank_state_s;

    cldc_bank_state_s s_q;
    cldc_bank_state_s s_d;

    always_comb begin
        s_d = s_q;
        // a refused write is dropped whole; the bus answer tells software
        if (wreq.en && !lock && (32'(wreq.idx) < COUNT)) begin
            s_d.w[wreq.idx] = cldc_merge(s_q.w[wreq.idx], wreq.data, wreq.strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '{w: '{default: RST_WORD}};
        end else begin
            s_q <= s_d;
        end
    end

    assign words = s_q.w;

endmodule

// ---- verilog/cldc_top.sv ----
// configuration lock and debug control: axi4-lite slave holding configuration_control and two lockable banks.
// assumes system_unlocked comes from unlock logic on aclk, and one write and one read at most in flight.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cldc_top
    import cldc_pkg::*;
#(
    parameter int unsigned PPS_COUNT = 8,
    parameter int unsigned PMD_COUNT = 4
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
    input  wire logic [2:0]                  s_axi_awprot,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [DATA_W-1:0]           s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ADDR_W-1:0]           s_axi_araddr,
    input  wire logic [2:0]                  s_axi_arprot,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [DATA_W-1:0]                s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        system_unlocked,
    output cldc_cfg_s                        cfg,
    output logic [PPS_COUNT-1:0][DATA_W-1:0] pin_select_mapping,
    output logic [PMD_COUNT-1:0][DATA_W-1:0] module_disable_regs
);

    if (PPS_COUNT < 1 || PPS_COUNT > MAX_WORDS || PMD_COUNT < 1 || PMD_COUNT > MAX_WORDS) begin : g_bad_count
        $error("cldc_top: bank sizes out of range");
    end

    typedef struct packed {
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_full;
        logic [DATA_W-1:0] w_data;
        logic [3:0]        w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        cldc_cfg_s         cfg;
    } cldc_state_s;

    cldc_state_s s_q;
    cldc_state_s s_d;
    cldc_wreq_s  pps_wreq;
    cldc_wreq_s  pmd_wreq;
    cldc_decode_s wr_dec;
    cldc_decode_s rd_dec;
    logic        wr_fire;

    // decoding shared by the write and read paths
    function automatic cldc_decode_s decode(input logic [ADDR_W-1:0] addr);
        cldc_decode_s d;
        d.idx    = addr[IDX_W+1:2];
        d.region = CLDC_RG_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[ADDR_W-1:8])
                REGION_CFG: begin
                    if (addr == CFG_OFFSET) begin
                        d.region = CLDC_RG_CFG;
                    end
                end
                REGION_PPS: begin
                    if (32'(d.idx) < PPS_COUNT) begin
                        d.region = CLDC_RG_PPS;
                    end
                end
                REGION_PMD: begin
                    if (32'(d.idx) < PMD_COUNT) begin
                        d.region = CLDC_RG_PMD;
                    end
                end
                default: begin
                    d.region = CLDC_RG_NONE;
                end
            endcase
        end
        return d;
    endfunction

    function automatic logic [DATA_W-1:0] cfg_word(input cldc_cfg_s c);
        logic [DATA_W-1:0] w;
        w = CFG_READ_ONES;
        w[BIT_PIN_LOCK] = c.pin_select_lock;
        w[BIT_MOD_LOCK] = c.module_disable_lock;
        w[BIT_DBG_EN]   = c.debug_port_enable;
        w[BIT_TDO_SEL]  = c.two_wire_data_out_select;
        return w; // bits 2:1 read as one, all bits other than 13, 12 and 3:0 stay zero
    endfunction

    assign wr_fire = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign wr_dec  = decode(s_q.aw_addr);
    assign rd_dec  = decode(s_axi_araddr);

    always_comb begin
        pps_wreq      = '0;
        pps_wreq.en   = wr_fire && (wr_dec.region == CLDC_RG_PPS);
        pps_wreq.idx  = wr_dec.idx;
        pps_wreq.data = s_q.w_data;
        pps_wreq.strb = s_q.w_strb;
        pmd_wreq      = pps_wreq;
        pmd_wreq.en   = wr_fire && (wr_dec.region == CLDC_RG_PMD);
    end

    always_comb begin
        s_d = s_q;
        // address and data are taken in either order and held until both are present
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_full = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            unique case (wr_dec.region)
                CLDC_RG_CFG: begin
                    // reserved bits are simply not stored
                    if (s_q.w_strb[BIT_DBG_EN/8]) begin
                        s_d.cfg.debug_port_enable = s_q.w_data[BIT_DBG_EN];
                    end
                    if (s_q.w_strb[BIT_TDO_SEL/8]) begin
                        s_d.cfg.two_wire_data_out_select = s_q.w_data[BIT_TDO_SEL];
                    end
                    // lock bits move only under the unlock qualifier; other fields still land
                    if (s_q.w_strb[BIT_PIN_LOCK/8] && system_unlocked) begin
                        s_d.cfg.pin_select_lock     = s_q.w_data[BIT_PIN_LOCK];
                        s_d.cfg.module_disable_lock = s_q.w_data[BIT_MOD_LOCK];
                    end
                end
                CLDC_RG_PPS: begin
                    if (s_q.cfg.pin_select_lock) begin
                        s_d.bresp = RESP_SLVERR;
                    end
                end
                CLDC_RG_PMD: begin
                    if (s_q.cfg.module_disable_lock) begin
                        s_d.bresp = RESP_SLVERR;
                    end
                end
                CLDC_RG_NONE: begin
                    s_d.bresp = RESP_DECERR;
                end
            endcase
        end
        s_d.awready = !s_d.aw_full && !s_d.bvalid;
        s_d.wready  = !s_d.w_full && !s_d.bvalid;

        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            unique case (rd_dec.region)
                CLDC_RG_CFG: s_d.rdata = cfg_word(s_q.cfg);
                CLDC_RG_PPS: s_d.rdata = pin_select_mapping[rd_dec.idx];
                CLDC_RG_PMD: s_d.rdata = module_disable_regs[rd_dec.idx];
                CLDC_RG_NONE: begin
                    s_d.rdata = RST_WORD;
                    s_d.rresp = RESP_DECERR;
                end
            endcase
        end
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q         <= '0;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.cfg     <= '{pin_select_lock:          RST_PIN_LOCK,
                             module_disable_lock:      RST_MOD_LOCK,
                             debug_port_enable:        RST_DBG_EN,
                             two_wire_data_out_select: RST_TDO_SEL};
        end else begin
            s_q <= s_d;
        end
    end

    cldc_lock_bank #(
        .COUNT (PPS_COUNT)
    ) u_pps_bank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lock    (s_q.cfg.pin_select_lock),
        .wreq    (pps_wreq),
        .words   (pin_select_mapping)
    );

    cldc_lock_bank #(
        .COUNT (PMD_COUNT)
    ) u_pmd_bank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lock    (s_q.cfg.module_disable_lock),
        .wreq    (pmd_wreq),
        .words   (module_disable_regs)
    );

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign cfg           = s_q.cfg;

    // helper for checking that an accepted bank write lands in the addressed word
    logic [IDX_W-1:0]  chk_idx_q;
    logic [DATA_W-1:0] chk_data_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_idx_q  <= '0;
            chk_data_q <= '0;
        end else if (wr_fire) begin
            chk_idx_q  <= wr_dec.idx;
            chk_data_q <= s_q.w_data;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_pps_lock_hold: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_PPS && cfg.pin_select_lock)
        |=> $stable(pin_select_mapping) && s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("locked pin-select write changed the mapping");

    chk_pps_write_lands: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_PPS && !cfg.pin_select_lock && s_q.w_strb == 4'hf)
        |=> pin_select_mapping[chk_idx_q] == chk_data_q && s_axi_bresp == RESP_OKAY)
        else $error("open pin-select write did not land");

    chk_pmd_lock_hold: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_PMD && cfg.module_disable_lock)
        |=> $stable(module_disable_regs) && s_axi_bresp == RESP_SLVERR)
        else $error("locked module-disable write changed a register");

    chk_pmd_write_lands: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_PMD && !cfg.module_disable_lock && s_q.w_strb == 4'hf)
        |=> module_disable_regs[chk_idx_q] == chk_data_q)
        else $error("open module-disable write did not land");

    chk_debug_en_follow: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_CFG && s_q.w_strb[0])
        |=> cfg.debug_port_enable == $past(s_q.w_data[BIT_DBG_EN]) ##1 $stable(cfg.debug_port_enable))
        else $error("debug port enable did not follow the write");

    chk_tdo_sel_follow: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_CFG && s_q.w_strb[0])
        |=> cfg.two_wire_data_out_select == $past(s_q.w_data[BIT_TDO_SEL]))
        else $error("data-out select did not follow the write");

    chk_cfg_read_shape: assert property (
        (s_axi_arvalid && s_axi_arready && rd_dec.region == CLDC_RG_CFG)
        |=> s_axi_rvalid && (s_axi_rdata & ~32'h0000_300f) == 32'h0 && s_axi_rdata[2:1] == 2'b11)
        else $error("control register read shows wrong reserved bits");

    chk_lock_unlock: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_CFG && !system_unlocked)
        |=> $stable(cfg.pin_select_lock) && $stable(cfg.module_disable_lock))
        else $error("lock bit moved without unlock");

    // the positive half: with the qualifier high both locks take the written byte
    chk_lock_with_unlock: assert property (
        (wr_fire && wr_dec.region == CLDC_RG_CFG && system_unlocked && s_q.w_strb[BIT_PIN_LOCK/8])
        |=> cfg.pin_select_lock == $past(s_q.w_data[BIT_PIN_LOCK])
            && cfg.module_disable_lock == $past(s_q.w_data[BIT_MOD_LOCK]))
        else $error("lock bits did not follow an unlocked write");

endmodule

// ---- verification/testbench.sv ----
// self-checking bench for cldc_top: axi4-lite master tasks and directed register tests.
// assumes the design answers every request eventually; a cycle ceiling cuts a hang short.
`timescale 1ns/1ps
module testbench
    import cldc_pkg::*;
;
    logic                 aclk;
    logic                 aresetn;
    logic [ADDR_W-1:0]    s_axi_awaddr;
    logic                 s_axi_awvalid;
    logic                 s_axi_awready;
    logic [DATA_W-1:0]    s_axi_wdata;
    logic [3:0]           s_axi_wstrb;
    logic                 s_axi_wvalid;
    logic                 s_axi_wready;
    logic [1:0]           s_axi_bresp;
    logic                 s_axi_bvalid;
    logic                 s_axi_bready;
    logic [ADDR_W-1:0]    s_axi_araddr;
    logic                 s_axi_arvalid;
    logic                 s_axi_arready;
    logic [DATA_W-1:0]    s_axi_rdata;
    logic [1:0]           s_axi_rresp;
    logic                 s_axi_rvalid;
    logic                 s_axi_rready;
    logic                 system_unlocked;
    cldc_cfg_s            cfg;
    logic [7:0][DATA_W-1:0] pin_select_mapping;
    logic [3:0][DATA_W-1:0] module_disable_regs;
    int                   errors;
    int                   checked;
    int                   cycles = 0;

    cldc_top #(.PPS_COUNT(8), .PMD_COUNT(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .system_unlocked(system_unlocked), .cfg(cfg),
        .pin_select_mapping(pin_select_mapping), .module_disable_regs(module_disable_regs)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // expected control word: state bits at their positions, fixed-one bits merged in
    function automatic logic [31:0] cfgw(input logic pl, input logic ml, input logic de, input logic ts);
        logic [31:0] w;
        w = CFG_READ_ONES;
        w[BIT_PIN_LOCK] = pl;
        w[BIT_MOD_LOCK] = ml;
        w[BIT_DBG_EN] = de;
        w[BIT_TDO_SEL] = ts;
        return w;
    endfunction

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        // start one edge later so no signal is assigned twice in one time step
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, ed, "read data");
        check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
        s_axi_rready <= 1'b0;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            $display("Error at %0t: run exceeded its cycle ceiling", $time);
            end_of_test();
        end
    end

    initial begin
        errors = 0;
        checked = 0;
        aresetn = 1'b0;
        system_unlocked = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;

        // reset state of the control word and its outputs
        axi_read(CFG_OFFSET, cfgw(1'b0, 1'b0, 1'b1, 1'b1), RESP_OKAY);
        check({28'h0, cfg}, 32'h0000_0003, "cfg after reset");
        $display("test reset_values done");

        // lock bits ignore a write without the unlock qualifier, debug bits still land
        axi_write(CFG_OFFSET, 32'hffff_fff6, 4'hf, RESP_OKAY);
        check({28'h0, cfg}, 32'h0000_0000, "cfg after locked-out write");
        axi_read(CFG_OFFSET, cfgw(1'b0, 1'b0, 1'b0, 1'b0), RESP_OKAY);
        $display("test no_unlock done");

        // both banks writable while their locks are clear, byte strobes merge
        axi_write(PPS_BASE + 12'h01c, 32'h1234_5678, 4'hf, RESP_OKAY);
        axi_write(PMD_BASE + 12'h00c, 32'ha5a5_5a5a, 4'hf, RESP_OKAY);
        axi_write(PPS_BASE, 32'hdead_beef, 4'hf, RESP_OKAY);
        axi_write(PPS_BASE, 32'h0000_00aa, 4'h1, RESP_OKAY);
        check(pin_select_mapping[7], 32'h1234_5678, "pin select word 7");
        check(module_disable_regs[3], 32'ha5a5_5a5a, "module disable word 3");
        axi_read(PPS_BASE, 32'hdead_beaa, RESP_OKAY);
        $display("test open_banks done");

        // pin-select lock set under unlock: pin-select refused, module-disable still open
        system_unlocked <= 1'b1;
        axi_write(CFG_OFFSET, 32'h0000_2009, 4'hf, RESP_OKAY);
        system_unlocked <= 1'b0;
        check({28'h0, cfg}, 32'h0000_000b, "cfg with pin lock");
        axi_read(CFG_OFFSET, cfgw(1'b1, 1'b0, 1'b1, 1'b1), RESP_OKAY);
        axi_write(PPS_BASE + 12'h01c, 32'h0000_0000, 4'hf, RESP_SLVERR);
        check(pin_select_mapping[7], 32'h1234_5678, "pin select word 7 locked");
        axi_write(PMD_BASE + 12'h00c, 32'h0000_0001, 4'hf, RESP_OKAY);
        check(module_disable_regs[3], 32'h0000_0001, "module disable word 3 open");
        $display("test pin_lock done");

        // swap to module-disable lock; a write without byte 1 leaves both locks alone
        system_unlocked <= 1'b1;
        axi_write(CFG_OFFSET, 32'h0000_1000, 4'hf, RESP_OKAY);
        axi_write(CFG_OFFSET, 32'h0000_2000, 4'h1, RESP_OKAY);
        system_unlocked <= 1'b0;
        check({28'h0, cfg}, 32'h0000_0004, "cfg with module lock");
        axi_write(PPS_BASE + 12'h01c, 32'h0000_0055, 4'hf, RESP_OKAY);
        check(pin_select_mapping[7], 32'h0000_0055, "pin select word 7 reopened");
        axi_write(PMD_BASE + 12'h00c, 32'h0000_0002, 4'hf, RESP_SLVERR);
        check(module_disable_regs[3], 32'h0000_0001, "module disable word 3 locked");
        axi_read(PMD_BASE + 12'h00c, 32'h0000_0001, RESP_OKAY);
        $display("test module_lock done");

        // unmapped and unaligned accesses have no effect
        axi_write(12'h300, 32'hffff_ffff, 4'hf, RESP_DECERR);
        axi_read(12'h300, 32'h0000_0000, RESP_DECERR);
        axi_write(12'h001, 32'hffff_ffff, 4'hf, RESP_DECERR);
        axi_write(CFG_OFFSET, 32'h0000_0000, 4'hf, RESP_OKAY);
        axi_read(CFG_OFFSET, cfgw(1'b0, 1'b1, 1'b0, 1'b0), RESP_OKAY);
        $display("test unmapped done");

        end_of_test();
    end
endmodule
